// ===== verilog/crp_pkg.sv
// shared constants and types of the command record/playback sequencer
package crp_pkg;
   localparam int          CMD_W          = 32;          // one stored command line
   localparam int          ARG_W          = 16;          // numeric argument of a setting
   localparam int          DEPTH_DEF      = 64;          // default buffer capacity
   localparam longint      SEC_NS         = 1000000000;  // one second in ns
   localparam longint      CLK_NS         = 10;          // clk period in ns
   localparam int          SEC_CYCLES     = int'(SEC_NS / CLK_NS);
   localparam logic [7:0]  DWELL_MAX      = 8'hB4;       // 180 s
   localparam logic [7:0]  DWELL_RESET    = 8'h00;
   localparam logic [15:0] REP_MAX        = 16'hFFFE;    // 65534 passes
   localparam logic [15:0] REP_ENDLESS    = 16'hFFFF;    // loops until stopped
   localparam logic [15:0] REP_RESET      = 16'h0001;    // single pass
   localparam logic        LOCK_RESET     = 1'b0;        // panel unlocked

   typedef enum logic [3:0] {
      CRP_K_OTHER      = 4'h0,
      CRP_K_REC_START  = 4'h1,
      CRP_K_REC_STOP   = 4'h2,
      CRP_K_TRIGGER    = 4'h3,
      CRP_K_INIT_IMM   = 4'h4,
      CRP_K_PROG_RUN   = 4'h5,
      CRP_K_PROG_STOP  = 4'h6,
      CRP_K_PROG_PAUSE = 4'h7,
      CRP_K_DWELL_SET  = 4'h8,
      CRP_K_REPEAT_SET = 4'h9,
      CRP_K_ENDLESS    = 4'hA,
      CRP_K_LIST_QUERY = 4'hB,
      CRP_K_LOCK_SET   = 4'hC,
      CRP_K_LOCK_QUERY = 4'hD
   } crp_kind_t;

   typedef enum logic [2:0] {
      CRP_S_IDLE  = 3'h0,
      CRP_S_ISSUE = 3'h1,
      CRP_S_EXEC  = 3'h2,
      CRP_S_DWELL = 3'h3,
      CRP_S_PAUSE = 3'h4
   } crp_state_t;
endpackage

// ===== verilog/crp_buf_if.sv
// write port and two read ports of the sequence buffer
interface crp_buf_if #(parameter int DEPTH = 64);
   localparam int IW = $clog2(DEPTH);
   logic                      wr_en;
   logic [IW-1:0]             wr_idx;
   logic [crp_pkg::CMD_W-1:0] wr_data;
   logic [IW-1:0]             rd_idx_a;
   logic [crp_pkg::CMD_W-1:0] rd_data_a;
   logic [IW-1:0]             rd_idx_b;
   logic [crp_pkg::CMD_W-1:0] rd_data_b;
   modport ctrl (output wr_en, wr_idx, wr_data, rd_idx_a, rd_idx_b,
                 input rd_data_a, rd_data_b);
   modport mem  (input wr_en, wr_idx, wr_data, rd_idx_a, rd_idx_b,
                 output rd_data_a, rd_data_b);
endinterface

// ===== verilog/crp_seq_buf.sv
// flip-flop storage of recorded command lines
module crp_seq_buf #(
   parameter int DEPTH = 64
) (
   input  wire logic  clk,
   crp_buf_if.mem     bus
);
   logic [crp_pkg::CMD_W-1:0] mem_q [DEPTH];

   // -----------------------------------------------------------------
   // storage
   // -----------------------------------------------------------------
   // contents need no reset: the fill count alone says what is valid
   always_ff @(posedge clk)
   begin
      if (bus.wr_en)
      begin
         mem_q[bus.wr_idx] <= bus.wr_data;
      end
   end

   // both readers see the array without delay
   assign bus.rd_data_a = mem_q[bus.rd_idx_a];
   assign bus.rd_data_b = mem_q[bus.rd_idx_b];
endmodule

// ===== verilog/crp_sec_tick.sv
// one-second enable pulse, restartable so each delay gets whole seconds
module crp_sec_tick #(
   parameter int CYCLES = 100000000
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic clr,
   output logic      tick
);
   localparam int CW = $clog2(CYCLES);
   logic [CW-1:0] cnt_q;

   // -----------------------------------------------------------------
   // divider
   // -----------------------------------------------------------------
   // clr realigns the second boundary to the start of a delay
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end
      else
      begin
         tick <= 1'b0;
         if (clr)
         begin
            cnt_q <= '0;
         end
         else if (cnt_q == CW'(CYCLES - 1))
         begin
            cnt_q <= '0;
            tick  <= 1'b1;
         end
         else
         begin
            cnt_q <= cnt_q + 1'b1;
         end
      end
   end
endmodule

// ===== verilog/crp_sequencer.sv
// command recorder, lister and timed replay sequencer with panel lockout
module crp_sequencer #(
   parameter int DEPTH      = crp_pkg::DEPTH_DEF,
   parameter int SEC_CYCLES = crp_pkg::SEC_CYCLES
) (
   input  wire logic                      clk,
   input  wire logic                      arst_n,
   input  wire logic                      cmd_valid,
   input  wire crp_pkg::crp_kind_t        cmd_kind,
   input  wire logic [crp_pkg::CMD_W-1:0] cmd_word,
   input  wire logic [crp_pkg::ARG_W-1:0] cmd_arg,
   input  wire logic                      cmd_from_replay,
   input  wire logic                      esc_abort,
   input  wire logic                      disp_done,
   input  wire logic                      list_ready,
   input  wire logic                      pwr_good_raw,
   input  wire logic                      btn_raw,
   input  wire logic                      knob_raw,
   output logic                           disp_valid,
   output logic [crp_pkg::CMD_W-1:0]      disp_word,
   output logic                           list_valid,
   output logic [crp_pkg::CMD_W-1:0]      list_word,
   output logic                           list_last,
   output logic                           lock_resp_valid,
   output logic                           lock_resp,
   output logic                           panel_locked,
   output logic                           panel_evt,
   output logic                           lockout_show,
   output logic                           recording,
   output crp_pkg::crp_state_t            run_state,
   output logic [7:0]                     dwell_now,
   output logic [15:0]                    repeat_now
);
   localparam int            IW      = $clog2(DEPTH);
   localparam logic [IW:0]   FULL_AT = (IW + 1)'(DEPTH - 1);

   crp_buf_if #(.DEPTH(DEPTH)) buf_if ();

   crp_pkg::crp_state_t st_q;
   logic [IW:0]         len_q;
   logic [IW:0]         rep_idx_q;
   logic [IW:0]         list_idx_q;
   logic [15:0]         pass_q;
   logic [7:0]          dwl_cnt_q;
   logic [7:0]          dwell_d;
   logic                list_busy_q;
   logic                sec_tick;
   logic                sec_clr;
   logic [2:0]          pwr_s_q;
   logic [2:0]          btn_s_q;
   logic [2:0]          knob_s_q;
   logic                pwr_ok;
   logic                hcv;
   logic                run_req;
   logic                active;
   logic [IW:0]         n_cmds;

   // -----------------------------------------------------------------
   // input synchronisers and command decode
   // -----------------------------------------------------------------
   // stage 0 feeds only stage 1; stages 1 and 2 feed edge detection
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pwr_s_q  <= 3'h0;
         btn_s_q  <= 3'h0;
         knob_s_q <= 3'h0;
      end
      else
      begin
         pwr_s_q  <= {pwr_s_q[1:0], pwr_good_raw};
         btn_s_q  <= {btn_s_q[1:0], btn_raw};
         knob_s_q <= {knob_s_q[1:0], knob_raw};
      end
   end

   // while recording, commands are only stored, never acted upon here
   assign pwr_ok  = pwr_s_q[1];
   assign hcv     = cmd_valid && !recording;
   assign run_req = hcv && (cmd_kind == crp_pkg::CRP_K_TRIGGER  ||
                            cmd_kind == crp_pkg::CRP_K_INIT_IMM ||
                            cmd_kind == crp_pkg::CRP_K_PROG_RUN);
   assign active  = (st_q != crp_pkg::CRP_S_IDLE);
   // the stored stop-record line is listed but never replayed
   assign n_cmds  = (len_q == '0) ? '0 : len_q - 1'b1;

   // -----------------------------------------------------------------
   // panel lockout
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         panel_locked    <= crp_pkg::LOCK_RESET;
         lock_resp_valid <= 1'b0;
         lock_resp       <= 1'b0;
         panel_evt       <= 1'b0;
         lockout_show    <= 1'b0;
      end
      else
      begin
         if (hcv && cmd_kind == crp_pkg::CRP_K_LOCK_SET)
         begin
            panel_locked <= cmd_arg[0];
         end
         lock_resp_valid <= hcv && cmd_kind == crp_pkg::CRP_K_LOCK_QUERY;
         lock_resp       <= panel_locked;
         // a locked panel only lights the lockout message
         panel_evt    <= !panel_locked && ((btn_s_q[1] && !btn_s_q[2]) ||
                                           (knob_s_q[1] != knob_s_q[2]));
         lockout_show <= panel_locked && ((btn_s_q[1] && !btn_s_q[2]) ||
                                          (knob_s_q[1] != knob_s_q[2]));
      end
   end

   // -----------------------------------------------------------------
   // settings: dwell and repeat
   // -----------------------------------------------------------------
   // out-of-range dwell values are refused and leave the old one
   always_comb
   begin
      dwell_d = dwell_now;
      if (hcv && cmd_kind == crp_pkg::CRP_K_DWELL_SET && cmd_arg <= 16'(crp_pkg::DWELL_MAX))
      begin
         dwell_d = cmd_arg[7:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         dwell_now  <= crp_pkg::DWELL_RESET;
         repeat_now <= crp_pkg::REP_RESET;
      end
      else
      begin
         dwell_now <= dwell_d;
         // a running or paused program keeps its pass count
         if (hcv && !active)
         begin
            if (cmd_kind == crp_pkg::CRP_K_REPEAT_SET && cmd_arg != '0 &&
                cmd_arg <= crp_pkg::REP_MAX)
            begin
               repeat_now <= cmd_arg;
            end
            else if (cmd_kind == crp_pkg::CRP_K_ENDLESS)
            begin
               repeat_now <= crp_pkg::REP_ENDLESS;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // recording
   // -----------------------------------------------------------------
   // one slot is always kept back so the stop line is never lost
   always_comb
   begin
      buf_if.wr_en   = 1'b0;
      buf_if.wr_idx  = len_q[IW-1:0];
      buf_if.wr_data = cmd_word;
      if (cmd_valid && recording && !cmd_from_replay && pwr_ok)
      begin
         if (cmd_kind == crp_pkg::CRP_K_REC_STOP)
         begin
            buf_if.wr_en = 1'b1;
         end
         else if (cmd_kind != crp_pkg::CRP_K_REC_START && len_q < FULL_AT)
         begin
            buf_if.wr_en = 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         len_q     <= '0;
         recording <= 1'b0;
      end
      else if (!pwr_ok)
      begin
         len_q     <= '0;
         recording <= 1'b0;
      end
      else if (cmd_valid && !cmd_from_replay && cmd_kind == crp_pkg::CRP_K_REC_START)
      begin
         len_q     <= '0;
         recording <= 1'b1;
      end
      else
      begin
         if (buf_if.wr_en)
         begin
            len_q <= len_q + 1'b1;
         end
         if (cmd_valid && recording && cmd_kind == crp_pkg::CRP_K_REC_STOP)
         begin
            recording <= 1'b0;
         end
      end
   end

   // -----------------------------------------------------------------
   // replay state machine
   // -----------------------------------------------------------------
   assign buf_if.rd_idx_a = rep_idx_q[IW-1:0];
   assign sec_clr         = (st_q == crp_pkg::CRP_S_EXEC) && disp_done;

   crp_sec_tick #(.CYCLES(SEC_CYCLES)) u_tick (
      .clk    (clk),
      .arst_n (arst_n),
      .clr    (sec_clr),
      .tick   (sec_tick)
   );

   // abort sources outrank pause, pause outranks the sequence itself
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         st_q       <= crp_pkg::CRP_S_IDLE;
         rep_idx_q  <= '0;
         pass_q     <= '0;
         dwl_cnt_q  <= '0;
         disp_valid <= 1'b0;
         disp_word  <= '0;
      end
      else
      begin
         disp_valid <= 1'b0;
         if (!pwr_ok || esc_abort || recording ||
             (hcv && cmd_kind == crp_pkg::CRP_K_PROG_STOP))
         begin
            st_q <= crp_pkg::CRP_S_IDLE;
         end
         else if (active && hcv && cmd_kind == crp_pkg::CRP_K_PROG_PAUSE)
         begin
            st_q <= crp_pkg::CRP_S_PAUSE;
         end
         else
         begin
            case (st_q)
               crp_pkg::CRP_S_IDLE:
               begin
                  if (run_req && n_cmds != '0)
                  begin
                     rep_idx_q <= '0;
                     pass_q    <= '0;
                     st_q      <= crp_pkg::CRP_S_ISSUE;
                  end
               end
               crp_pkg::CRP_S_ISSUE:
               begin
                  if (rep_idx_q < n_cmds)
                  begin
                     disp_valid <= 1'b1;
                     disp_word  <= buf_if.rd_data_a;
                     rep_idx_q  <= rep_idx_q + 1'b1;
                     st_q       <= crp_pkg::CRP_S_EXEC;
                  end
                  else if (repeat_now == crp_pkg::REP_ENDLESS ||
                           pass_q + 16'h0001 < repeat_now)
                  begin
                     pass_q    <= pass_q + 16'h0001;
                     rep_idx_q <= '0;
                  end
                  else
                  begin
                     st_q <= crp_pkg::CRP_S_IDLE;
                  end
               end
               crp_pkg::CRP_S_EXEC:
               begin
                  // the delay starts once the processor has run the line
                  if (disp_done)
                  begin
                     dwl_cnt_q <= dwell_d;
                     st_q      <= crp_pkg::CRP_S_DWELL;
                  end
               end
               crp_pkg::CRP_S_DWELL:
               begin
                  if (dwl_cnt_q == 8'h00)
                  begin
                     st_q <= crp_pkg::CRP_S_ISSUE;
                  end
                  else if (sec_tick)
                  begin
                     dwl_cnt_q <= dwl_cnt_q - 8'h01;
                  end
               end
               crp_pkg::CRP_S_PAUSE:
               begin
                  // rep_idx_q already names the line after the halted one
                  if (run_req)
                  begin
                     st_q <= crp_pkg::CRP_S_ISSUE;
                  end
               end
               default:
               begin
                  st_q <= crp_pkg::CRP_S_IDLE;
               end
            endcase
         end
      end
   end

   assign run_state = st_q;

   // -----------------------------------------------------------------
   // listing stream
   // -----------------------------------------------------------------
   assign buf_if.rd_idx_b = list_idx_q[IW-1:0];

   // a word stays on list_word until list_ready takes it
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         list_busy_q <= 1'b0;
         list_idx_q  <= '0;
         list_valid  <= 1'b0;
         list_word   <= '0;
         list_last   <= 1'b0;
      end
      else
      begin
         if (list_valid && list_ready)
         begin
            list_valid <= 1'b0;
         end
         if (!list_busy_q)
         begin
            if (hcv && cmd_kind == crp_pkg::CRP_K_LIST_QUERY && len_q != '0)
            begin
               list_busy_q <= 1'b1;
               list_idx_q  <= '0;
            end
         end
         else if (!list_valid || list_ready)
         begin
            if (list_idx_q < len_q)
            begin
               list_valid <= 1'b1;
               list_word  <= buf_if.rd_data_b;
               list_last  <= (list_idx_q + 1'b1 == len_q);
               list_idx_q <= list_idx_q + 1'b1;
            end
            else
            begin
               list_busy_q <= 1'b0;
            end
         end
      end
   end

   crp_seq_buf #(.DEPTH(DEPTH)) u_buf (
      .clk (clk),
      .bus (buf_if)
   );

   // -----------------------------------------------------------------
   // checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_run_from_idle;
      st_q == crp_pkg::CRP_S_IDLE && run_req && n_cmds != '0 && pwr_ok && !esc_abort;
   endsequence

   sequence s_list_start;
      !list_busy_q && hcv && cmd_kind == crp_pkg::CRP_K_LIST_QUERY && len_q != '0;
   endsequence

   AST_REPEAT_HELD: assert property (active && hcv |=> $stable(repeat_now))
      else $error("repeat setting changed while program active");
   AST_START_CLEARS: assert property (cmd_valid && !cmd_from_replay &&
      cmd_kind == crp_pkg::CRP_K_REC_START |=> len_q == '0 && (recording || !pwr_ok))
      else $error("record start did not empty the buffer");
   AST_PWR_CLEAR: assert property (!pwr_ok |=> len_q == '0 && !recording)
      else $error("buffer survived power loss");
   AST_STOP_ENDS: assert property (hcv && cmd_kind == crp_pkg::CRP_K_PROG_STOP
      |=> st_q == crp_pkg::CRP_S_IDLE && !disp_valid)
      else $error("program stop did not end replay");
   AST_ESC_ABORT: assert property (esc_abort |=> st_q == crp_pkg::CRP_S_IDLE)
      else $error("escape did not abort replay");
   AST_LOCK_SILENT: assert property ($past(panel_locked) |-> !panel_evt)
      else $error("panel event passed while locked");
   AST_RUN_DISPATCH: assert property (s_run_from_idle |=> ##1
      (disp_valid || st_q == crp_pkg::CRP_S_IDLE || st_q == crp_pkg::CRP_S_PAUSE))
      else $error("run request did not dispatch the first line");
   AST_DISP_PULSE: assert property (disp_valid |=> !disp_valid)
      else $error("dispatch strobe longer than one cycle");
   AST_LIST_FIRST: assert property (s_list_start |=> ##1
      (list_valid && list_idx_q == (IW + 1)'(1)) || len_q == '0)
      else $error("listing did not start at the first line");
   AST_DWELL_LOAD: assert property (st_q == crp_pkg::CRP_S_EXEC && disp_done &&
      pwr_ok && !esc_abort && !hcv |=> dwl_cnt_q == dwell_now && dwl_cnt_q <= 8'hB4)
      else $error("dwell delay not loaded from the live setting");
endmodule

// ===== tb/crp_proc_model.sv
// command processor model that finishes each dispatched line
module crp_proc_model #(
   parameter int LAT = 3
) (
   input  wire logic clk,
   input  wire logic arst_n,
   input  wire logic disp_valid,
   output logic      disp_done
);
   timeunit 1ns;
   timeprecision 100ps;
   int cnt;
   // runs a line like a host command, done only after a dispatch
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         cnt       <= 0;
         disp_done <= 1'b0;
      end
      else
      begin
         disp_done <= (cnt == 1);
         cnt       <= disp_valid ? LAT : (cnt > 0 ? cnt - 1 : 0);
      end
   end
endmodule

// ===== tb/tb_top.sv
// self-checking bench of the record/playback sequencer
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic               clk = 1'b0, arst_n = 1'b0, cmd_valid = 1'b0, esc_abort = 1'b0;
   crp_pkg::crp_kind_t cmd_kind = crp_pkg::CRP_K_OTHER;
   logic [31:0]        cmd_word = 32'h0, disp_word, list_word;
   logic [15:0]        cmd_arg = 16'h0, repeat_now;
   logic               list_ready = 1'b1, pwr_good_raw = 1'b1, btn_raw = 1'b0;
   logic               disp_done, disp_valid, list_valid, list_last, lock_resp_valid;
   logic               lock_resp, panel_locked, panel_evt, lockout_show, recording;
   crp_pkg::crp_state_t run_state;
   logic [7:0]         dwell_now;
   int                 errors = 0, checks = 0, evt_n = 0, lck_n = 0;
   logic               list_done = 1'b0;
   logic [31:0]        lq[$], dq[$];
   crp_sequencer #(.DEPTH(8), .SEC_CYCLES(20)) dut (.clk, .arst_n, .cmd_valid, .cmd_kind,
      .cmd_word, .cmd_arg, .cmd_from_replay(1'b0), .esc_abort, .disp_done,
      .list_ready, .pwr_good_raw, .btn_raw, .knob_raw(1'b0), .disp_valid, .disp_word,
      .list_valid, .list_word, .list_last, .lock_resp_valid, .lock_resp, .panel_locked,
      .panel_evt, .lockout_show, .recording, .run_state, .dwell_now, .repeat_now);
   crp_proc_model pm (.clk, .arst_n, .disp_valid, .disp_done);
   always #5 clk = ~clk;
   // collectors of what leaves the block, sampled at the edge
   always @(posedge clk)
   begin
      if (list_valid === 1'b1 && list_ready === 1'b1) lq.push_back(list_word);
      if (list_valid === 1'b1 && list_last === 1'b1) list_done = 1'b1;
      if (disp_valid === 1'b1) dq.push_back(disp_word);
      if (panel_evt === 1'b1) evt_n++;
      if (lockout_show === 1'b1) lck_n++;
   end
   task print_verdict;
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task chk(string what, logic [31:0] exp, logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[ERR] %s exp %h got %h", what, exp, got);
      end
   endtask
   task cmd(crp_pkg::crp_kind_t k, logic [15:0] a = 16'h0, logic [31:0] w = 32'h0);
      @(posedge clk);
      {cmd_valid, cmd_kind, cmd_arg, cmd_word} <= {1'b1, k, a, w};
      @(posedge clk);
      cmd_valid <= 1'b0;
      #1;
   endtask
   // bounded wait: 0 end of listing, 1 replay idle, 2 at least n dispatches
   task wait_on(int mode, int n = 0);
      for (int i = 0; i < 3000; i++)
      begin
         @(posedge clk);
         #1;
         if (mode == 0 ? list_done :
             (mode == 1 ? run_state === crp_pkg::CRP_S_IDLE : dq.size() >= n)) return;
      end
      errors++;
      print_verdict;
   endtask
   task press(int evt, int lck);
      int e0, l0;
      e0 = evt_n;
      l0 = lck_n;
      @(posedge clk);
      btn_raw <= 1'b1;
      repeat (8) @(posedge clk);
      btn_raw <= 1'b0;
      repeat (8) @(posedge clk);
      chk("panel_evt", evt, evt_n - e0);
      chk("lockout", lck, lck_n - l0);
   endtask
   task t_settings;
      chk("rep_rst", 32'h1, repeat_now);
      chk("lock_rst", 32'h0, panel_locked);
      cmd(crp_pkg::CRP_K_DWELL_SET, 16'h00B4);
      chk("dwell", 32'hB4, dwell_now);
      cmd(crp_pkg::CRP_K_DWELL_SET, 16'h00B5);
      chk("dwell_big", 32'hB4, dwell_now);
      cmd(crp_pkg::CRP_K_DWELL_SET, 16'h0000);
      cmd(crp_pkg::CRP_K_REPEAT_SET, 16'h0000);
      chk("rep_zero", 32'h1, repeat_now);
      cmd(crp_pkg::CRP_K_REPEAT_SET, 16'hFFFE);
      chk("rep_max", 32'hFFFE, repeat_now);
      cmd(crp_pkg::CRP_K_ENDLESS);
      chk("rep_inf", 32'hFFFF, repeat_now);
   endtask
   task t_panel;
      cmd(crp_pkg::CRP_K_LOCK_SET, 16'h0001);
      chk("locked", 32'h1, panel_locked);
      cmd(crp_pkg::CRP_K_LOCK_QUERY);
      chk("resp", 32'h3, {lock_resp_valid, lock_resp});
      press(0, 1);
      cmd(crp_pkg::CRP_K_LOCK_SET, 16'h0000);
      press(1, 0);
   endtask
   // old program discarded; a setting kind is only stored while recording
   // lines arrive already parsed, so no link rate change is needed to load them
   task t_record_list;
      cmd(crp_pkg::CRP_K_REC_START);
      cmd(crp_pkg::CRP_K_OTHER, 16'h0, 32'h0000_00EE);
      cmd(crp_pkg::CRP_K_REC_STOP, 16'h0, 32'h0000_005E);
      cmd(crp_pkg::CRP_K_REC_START);
      cmd(crp_pkg::CRP_K_OTHER, 16'h0, 32'h0000_00A1);
      cmd(crp_pkg::CRP_K_DWELL_SET, 16'h0009, 32'h0000_00B2);
      cmd(crp_pkg::CRP_K_REC_STOP, 16'h0, 32'h0000_005E);
      chk("dwell_rec", 32'h0, dwell_now);
      lq.delete();
      cmd(crp_pkg::CRP_K_LIST_QUERY);
      wait_on(0);
      chk("list_n", 32'h3, lq.size());
      chk("list0", 32'hA1, lq[0]);
      chk("list1", 32'hB2, lq[1]);
      chk("list2", 32'h5E, lq[2]);
   endtask
   task t_replay;
      cmd(crp_pkg::CRP_K_REPEAT_SET, 16'h0002);
      dq.delete();
      cmd(crp_pkg::CRP_K_PROG_RUN);
      cmd(crp_pkg::CRP_K_REPEAT_SET, 16'h0005);
      chk("rep_run", 32'h2, repeat_now);
      wait_on(1);
      chk("disp_n", 32'h4, dq.size());
      chk("disp2", 32'hA1, dq[2]);
      chk("disp3", 32'hB2, dq[3]);
   endtask
   // pause keeps the place, run resumes after it; stop and escape end at once
   task t_pause_stop;
      dq.delete();
      cmd(crp_pkg::CRP_K_DWELL_SET, 16'h0002);
      cmd(crp_pkg::CRP_K_TRIGGER);
      wait_on(2, 1);
      cmd(crp_pkg::CRP_K_PROG_PAUSE);
      chk("paused", 32'h4, run_state);
      cmd(crp_pkg::CRP_K_INIT_IMM);
      wait_on(2, 2);
      chk("resumed", 32'hB2, dq[1]);
      cmd(crp_pkg::CRP_K_PROG_STOP);
      chk("stopped", 32'h0, run_state);
      cmd(crp_pkg::CRP_K_PROG_RUN);
      wait_on(2, 3);
      @(posedge clk);
      esc_abort <= 1'b1;
      @(posedge clk);
      esc_abort <= 1'b0;
      #1;
      chk("escaped", 32'h0, run_state);
   endtask
   task t_power;
      @(posedge clk);
      pwr_good_raw <= 1'b0;
      repeat (4) @(posedge clk);
      pwr_good_raw <= 1'b1;
      repeat (4) @(posedge clk);
      lq.delete();
      cmd(crp_pkg::CRP_K_LIST_QUERY);
      repeat (10) @(posedge clk);
      chk("list_off", 32'h0, lq.size());
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      t_settings;
      t_panel;
      t_record_list;
      t_replay;
      t_pause_stop;
      t_power;
      print_verdict;
   end
endmodule
